/* File: ais_sar.sv */
// Shared constants for the converter control block and its successive-approximation engine
package ais_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_INPUT_SELECT = 8'h00;
	localparam logic [7:0] OFF_PIN_CONFIG = 8'h04;
	localparam logic [7:0] OFF_SCAN_MASK = 8'h08;
	localparam logic [7:0] OFF_CONTROL = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_RESULT_BASE = 8'h40;
	// Input select register fields
	localparam int SEL_B_NEG_BIT = 31;
	localparam int SEL_B_POS_LSB = 24;
	localparam int SEL_A_NEG_BIT = 23;
	localparam int SEL_A_POS_LSB = 16;
	// Control register fields
	localparam int CTL_SAMPLE_BIT = 0;
	localparam int CTL_TRIG_LSB = 1;
	localparam int CTL_AUTO_BIT = 4;
	localparam int CTL_AUTO_SAMPLE_TIME_FIELD_LSB = 8;
	localparam int CTL_ALT_BIT = 13;
	localparam int CTL_SCAN_BIT = 14;
	localparam int CTL_SEQ_LSB = 16;
	// Status register fields
	localparam int STA_BUSY_BIT = 0;
	localparam int STA_DONE_BIT = 1;
	localparam int STA_SAMPLING_BIT = 2;
	localparam int STA_USE_B_BIT = 3;
	localparam int STA_IDX_LSB = 4;
	localparam int STA_CHAN_LSB = 8;
	// Trigger select codes
	localparam logic [2:0] TRIG_MANUAL = 3'h0;
	localparam logic [2:0] TRIG_AUTO = 3'h7;
	// Conversion timing in conversion clock periods (one clock_i cycle each)
	localparam int RES_BITS = 10;
	localparam int CONV_OVERHEAD = 2;
	localparam int CONV_PERIODS = RES_BITS + CONV_OVERHEAD;
	localparam int BUF_DEPTH = 16;
	localparam int NUM_PINS = 16;
	// Values after reset
	localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage : ais_pkg

// Successive-approximation engine: overhead periods, then one result bit per period
module ais_sar import ais_pkg::*; #(
	parameter int RES_W = RES_BITS,
	parameter int OVERHEAD = CONV_OVERHEAD
) (
	input wire logic clock_i, // Conversion clock
	input wire logic rstn_i, // Async reset, active low
	input wire logic start_i, // One-cycle start pulse
	input wire logic cmp_i, // Held sample at or above trial level
	output logic [RES_W-1:0] dac_o, // Trial code to the comparator DAC
	output logic busy_o, // Conversion running
	output logic done_o, // One-cycle pulse, result valid
	output logic [RES_W-1:0] result_o // Last finished result
);
	localparam int TOTAL = RES_W + OVERHEAD;
	localparam logic [RES_W-1:0] MSB_MASK = RES_W'(1) << (RES_W - 1);

	// Four-bit period counter, so longer conversions cannot be served
	if (RES_W < 2 || OVERHEAD < 1 || TOTAL > 15) begin : g_bad_widths
		$error("ais_sar: unsupported widths");
	end

	logic [3:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	logic [RES_W-1:0] acc_reg, acc_next;
	logic [RES_W-1:0] trial_reg, trial_next;
	logic [RES_W-1:0] res_reg, res_next;

	// Next state: overhead first, then resolve MSB down to LSB
	always_comb begin
		logic [RES_W-1:0] kept;
		logic [RES_W-1:0] next_mask;
		kept = acc_reg;
		next_mask = '0;
		cnt_next = cnt_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		acc_next = acc_reg;
		trial_next = trial_reg;
		res_next = res_reg;
		if (start_i && !busy_reg) begin
			busy_next = 1'b1;
			cnt_next = 4'h0;
			acc_next = '0;
			trial_next = '0;
		end else if (busy_reg) begin
			cnt_next = cnt_reg + 4'h1;
			if (cnt_reg >= 4'(OVERHEAD)) begin
				kept = cmp_i ? trial_reg : acc_reg; // RULE21
				acc_next = kept;
			end
			if (cnt_reg >= 4'(OVERHEAD - 1) && cnt_reg < 4'(TOTAL - 1)) begin
				next_mask = MSB_MASK >> (cnt_reg - 4'(OVERHEAD - 1)); // RULE21
				trial_next = kept | next_mask;
			end
			if (cnt_reg == 4'(TOTAL - 1)) begin
				busy_next = 1'b0; // RULE16
				done_next = 1'b1;
				res_next = kept;
				trial_next = '0;
			end
		end
	end

	// State registers
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_reg <= 4'h0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
			acc_reg <= '0;
			trial_reg <= '0;
			res_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
			acc_reg <= acc_next;
			trial_reg <= trial_next;
			res_reg <= res_next;
		end
	end

	assign dac_o = trial_reg;
	assign busy_o = busy_reg;
	assign done_o = done_reg;
	assign result_o = res_reg;
endmodule : ais_sar

/* File: ais_ctrl.sv */
// Converter input selection, pin configuration, scan and sample/convert sequencing
// Contract
// [RULE1] Second-set negative select bit 31: one picks analog pin one, zero negative reference.
// [RULE2] Second-set positive field 27-24 is a binary pin index, 0 to 15.
// [RULE3] First-set negative select bit 23: one picks analog pin one, zero negative reference.
// [RULE4] First-set positive field 19-16 is a binary pin index, 0 to 15.
// [RULE5] Software writes zero to reserved bits 28, 20 and upper halves.
// [RULE6] Unimplemented select register bits read zero; writes to them are dropped.
// [RULE7] Config bit one: pin digital, port read enabled, mux input tied to ground.
// [RULE8] Config bit zero: pin analog, sampled, port read returns one.
// [RULE9] Sixteen read-write pin configuration bits, all reset to zero.
// [RULE10] Scan includes pin n when mask bit n is one, skips it otherwise.
// [RULE11] Input connected to the hold amplifier while sampling, disconnected while converting.
// [RULE12] One hold amplifier fed from either set, optionally alternating per conversion.
// [RULE13] Scan steps the first set through masked pins, one per conversion.
// [RULE14] Software sets sample control to start acquisition and clears it to end.
// [RULE15] Automatic acquisition ends on trigger; auto time sets length in periods.
// [RULE16] Conversion lasts one period per bit plus two: 12 periods.
// [RULE17] Each finished conversion writes one of sixteen result buffer slots.
// [RULE18] Each new sequence starts storing at the first buffer slot.
// [RULE19] Trigger select 000: clearing sample control ends sampling, starts conversion.
// [RULE20] Auto-start one: sampling restarts after conversion, sample control set by hardware.
// [RULE21] Successive approximation resolves MSB first, one bit per period after overhead.
// [RULE22] Write index steps by one per stored result.
//
// The placing of the registers and strobed register access were decided locally.
module ais_ctrl import ais_pkg::*; (
	input wire logic clock_i, // Conversion clock, 25 MHz
	input wire logic rstn_i, // Async reset, active low
	input wire logic [7:0] addr_i, // Register byte address
	input wire logic [31:0] wdata_i, // Write data
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output logic [31:0] rdata_o, // Read data, cycle after strobe
	input wire logic trig_i, // External conversion trigger pulse
	input wire logic cmp_i, // Comparator result from analog core
	input wire logic [NUM_PINS-1:0] pin_level_i, // Raw digital pin levels
	output logic [NUM_PINS-1:0] port_read_o, // Digital port read values
	output logic [NUM_PINS-1:0] mux_ground_o, // Mux input tied to analog ground
	output logic [3:0] pos_sel_o, // Positive mux pin index
	output logic neg_sel_o, // Negative mux: 1 pin one, 0 reference
	output logic sha_connect_o, // Input connected to hold amplifier
	output logic [RES_BITS-1:0] dac_o // Trial code to comparator DAC
);
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} ais_state_e;

	// Lowest set mask bit after 'from', wrapping; 'from' if mask empty
	function automatic logic [3:0] ais_next_set(input logic [15:0] mask, input logic [3:0] from);
		logic [3:0] pick;
		logic found;
		logic [3:0] cand;
		pick = from;
		found = 1'b0;
		cand = 4'h0;
		for (int k = 1; k <= 16; k++) begin
			cand = 4'(from + 4'(k));
			if (!found && mask[cand]) begin
				pick = cand;
				found = 1'b1;
			end
		end
		return pick;
	endfunction : ais_next_set

	// Configuration and sequencer state
	ais_state_e state_reg, state_next;
	logic [3:0] a_pos_reg, a_pos_next, b_pos_reg, b_pos_next;
	logic a_neg_reg, a_neg_next, b_neg_reg, b_neg_next;
	logic [15:0] pcfg_reg, pcfg_next, scan_mask_reg, scan_mask_next;
	logic [2:0] trig_reg, trig_next;
	logic auto_reg, auto_next, alt_reg, alt_next, scan_en_reg, scan_en_next;
	logic [4:0] auto_sample_time_field_reg, auto_sample_time_field_next, sample_control_bit_cnt_reg, sample_control_bit_cnt_next;
	logic [3:0] seq_last_reg, seq_last_next, idx_reg, idx_next;
	logic [3:0] scan_ch_reg, scan_ch_next;
	logic alt_b_reg, alt_b_next, done_reg, done_next;
	logic [RES_BITS-1:0] buf_reg [BUF_DEPTH], buf_next [BUF_DEPTH];
	logic [31:0] rdata_reg, rdata_next;
	logic [3:0] pos_reg;
	logic neg_reg, sha_reg;
	logic [NUM_PINS-1:0] pin_meta_reg, pin_sync_reg, port_rd_reg;

	logic ctl_wr, trig_hit, start_conv, sar_busy, sar_done, use_b;
	logic [3:0] first_ch, scan_ch, pos_sel;
	logic [RES_BITS-1:0] sar_result;

	ais_sar #(.RES_W(RES_BITS), .OVERHEAD(CONV_OVERHEAD)) u_sar (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.start_i(start_conv),
		.cmp_i(cmp_i),
		.dac_o(dac_o),
		.busy_o(sar_busy),
		.done_o(sar_done),
		.result_o(sar_result)
	);

	// Mux selection; scanning only ever drives the first set
	assign first_ch = ais_next_set(scan_mask_reg, 4'hf);
	assign use_b = alt_reg && (idx_reg != 4'h0) && alt_b_reg; // RULE12
	assign scan_ch = (idx_reg == 4'h0) ? first_ch : scan_ch_reg; // RULE13
	assign pos_sel = use_b ? b_pos_reg : (scan_en_reg ? scan_ch : a_pos_reg); // RULE2 RULE4

	// Conversion trigger decode
	assign ctl_wr = wr_i && (addr_i == OFF_CONTROL);
	always_comb begin
		case (trig_reg)
			TRIG_MANUAL: trig_hit = ctl_wr && !wdata_i[CTL_SAMPLE_BIT]; // RULE19
			TRIG_AUTO: trig_hit = (auto_sample_time_field_reg != 5'h00) && (sample_control_bit_cnt_reg >= auto_sample_time_field_reg); // RULE15
			default: trig_hit = trig_i;
		endcase
	end
	assign start_conv = (state_reg == ST_SAMPLE) && trig_hit;

	// Register writes and sequencer next state
	always_comb begin
		state_next = state_reg;
		a_pos_next = a_pos_reg;
		b_pos_next = b_pos_reg;
		a_neg_next = a_neg_reg;
		b_neg_next = b_neg_reg;
		pcfg_next = pcfg_reg;
		scan_mask_next = scan_mask_reg;
		trig_next = trig_reg;
		auto_next = auto_reg;
		alt_next = alt_reg;
		scan_en_next = scan_en_reg;
		auto_sample_time_field_next = auto_sample_time_field_reg;
		seq_last_next = seq_last_reg;
		sample_control_bit_cnt_next = sample_control_bit_cnt_reg;
		idx_next = idx_reg;
		scan_ch_next = scan_ch_reg;
		alt_b_next = alt_b_reg;
		done_next = done_reg;
		buf_next = buf_reg;
		// Only implemented fields are stored; reserved bits are dropped
		if (wr_i && addr_i == OFF_INPUT_SELECT) begin
			b_neg_next = wdata_i[SEL_B_NEG_BIT]; // RULE1
			b_pos_next = wdata_i[SEL_B_POS_LSB +: 4]; // RULE2
			a_neg_next = wdata_i[SEL_A_NEG_BIT]; // RULE3
			a_pos_next = wdata_i[SEL_A_POS_LSB +: 4]; // RULE4 RULE6
		end
		if (wr_i && addr_i == OFF_PIN_CONFIG) pcfg_next = wdata_i[15:0]; // RULE9
		if (wr_i && addr_i == OFF_SCAN_MASK) scan_mask_next = wdata_i[15:0]; // RULE10
		if (ctl_wr) begin
			trig_next = wdata_i[CTL_TRIG_LSB +: 3];
			auto_next = wdata_i[CTL_AUTO_BIT];
			auto_sample_time_field_next = wdata_i[CTL_AUTO_SAMPLE_TIME_FIELD_LSB +: 5];
			alt_next = wdata_i[CTL_ALT_BIT];
			scan_en_next = wdata_i[CTL_SCAN_BIT];
			seq_last_next = wdata_i[CTL_SEQ_LSB +: 4];
		end
		// Done flag: software clear first so a hardware set in the same cycle wins
		if (wr_i && addr_i == OFF_STATUS && wdata_i[STA_DONE_BIT]) done_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (ctl_wr && wdata_i[CTL_SAMPLE_BIT]) begin
					state_next = ST_SAMPLE; // RULE14
					sample_control_bit_cnt_next = 5'h00;
				end
			end
			ST_SAMPLE: begin
				if (sample_control_bit_cnt_reg != 5'h1f) sample_control_bit_cnt_next = sample_control_bit_cnt_reg + 5'h01;
				if (start_conv) begin
					state_next = ST_CONVERT; // RULE11
					done_next = 1'b0;
				end else if (ctl_wr && !wdata_i[CTL_SAMPLE_BIT]) begin
					state_next = ST_IDLE; // RULE14
				end
			end
			ST_CONVERT: begin
				if (sar_done) begin
					buf_next[idx_reg] = sar_result; // RULE17
					done_next = 1'b1;
					if (idx_reg == seq_last_reg) idx_next = 4'h0; // RULE18
					else idx_next = idx_reg + 4'h1; // RULE22
					if (!use_b) scan_ch_next = ais_next_set(scan_mask_reg, scan_ch); // RULE10 RULE13
					alt_b_next = alt_reg && !use_b; // RULE12
					sample_control_bit_cnt_next = 5'h00;
					state_next = auto_reg ? ST_SAMPLE : ST_IDLE; // RULE20
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end

	// Read data mux, answered the cycle after the strobe
	always_comb begin
		rdata_next = RESET_WORD;
		if (rd_i) begin
			if (addr_i >= OFF_RESULT_BASE) begin
				if (addr_i[1:0] == 2'h0 && addr_i < OFF_RESULT_BASE + 8'(4 * BUF_DEPTH))
					rdata_next = 32'(buf_reg[4'(addr_i[5:2])]);
			end else begin
				case (addr_i)
					OFF_INPUT_SELECT: begin
						rdata_next[SEL_B_NEG_BIT] = b_neg_reg;
						rdata_next[SEL_B_POS_LSB +: 4] = b_pos_reg;
						rdata_next[SEL_A_NEG_BIT] = a_neg_reg;
						rdata_next[SEL_A_POS_LSB +: 4] = a_pos_reg; // RULE6
					end
					OFF_PIN_CONFIG: rdata_next[15:0] = pcfg_reg;
					OFF_SCAN_MASK: rdata_next[15:0] = scan_mask_reg;
					OFF_CONTROL: begin
						rdata_next[CTL_SAMPLE_BIT] = (state_reg == ST_SAMPLE);
						rdata_next[CTL_TRIG_LSB +: 3] = trig_reg;
						rdata_next[CTL_AUTO_BIT] = auto_reg;
						rdata_next[CTL_AUTO_SAMPLE_TIME_FIELD_LSB +: 5] = auto_sample_time_field_reg;
						rdata_next[CTL_ALT_BIT] = alt_reg;
						rdata_next[CTL_SCAN_BIT] = scan_en_reg;
						rdata_next[CTL_SEQ_LSB +: 4] = seq_last_reg;
					end
					OFF_STATUS: begin
						rdata_next[STA_BUSY_BIT] = (state_reg == ST_CONVERT);
						rdata_next[STA_DONE_BIT] = done_reg;
						rdata_next[STA_SAMPLING_BIT] = (state_reg == ST_SAMPLE);
						rdata_next[STA_USE_B_BIT] = use_b;
						rdata_next[STA_IDX_LSB +: 4] = idx_reg;
						rdata_next[STA_CHAN_LSB +: 4] = pos_sel;
					end
					default: rdata_next = RESET_WORD;
				endcase
			end
		end
	end

	// Register all state
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
			a_pos_reg <= 4'h0;
			b_pos_reg <= 4'h0;
			a_neg_reg <= 1'b0;
			b_neg_reg <= 1'b0;
			pcfg_reg <= 16'h0000; // RULE9
			scan_mask_reg <= 16'h0000;
			trig_reg <= TRIG_MANUAL;
			auto_reg <= 1'b0;
			alt_reg <= 1'b0;
			scan_en_reg <= 1'b0;
			auto_sample_time_field_reg <= 5'h00;
			seq_last_reg <= 4'h0;
			sample_control_bit_cnt_reg <= 5'h00;
			idx_reg <= 4'h0;
			scan_ch_reg <= 4'h0;
			alt_b_reg <= 1'b0;
			done_reg <= 1'b0;
			buf_reg <= '{default: '0};
			rdata_reg <= RESET_WORD;
		end else begin
			state_reg <= state_next;
			a_pos_reg <= a_pos_next;
			b_pos_reg <= b_pos_next;
			a_neg_reg <= a_neg_next;
			b_neg_reg <= b_neg_next;
			pcfg_reg <= pcfg_next;
			scan_mask_reg <= scan_mask_next;
			trig_reg <= trig_next;
			auto_reg <= auto_next;
			alt_reg <= alt_next;
			scan_en_reg <= scan_en_next;
			auto_sample_time_field_reg <= auto_sample_time_field_next;
			seq_last_reg <= seq_last_next;
			sample_control_bit_cnt_reg <= sample_control_bit_cnt_next;
			idx_reg <= idx_next;
			scan_ch_reg <= scan_ch_next;
			alt_b_reg <= alt_b_next;
			done_reg <= done_next;
			buf_reg <= buf_next;
			rdata_reg <= rdata_next;
		end
	end

	// Pin side outputs; pins pass two synchronizing flops, then the port read flop, since they are asynchronous
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			port_rd_reg <= '1;
			pos_reg <= 4'h0;
			neg_reg <= 1'b0;
			sha_reg <= 1'b0;
		end else begin
			pin_meta_reg <= pin_level_i;
			pin_sync_reg <= pin_meta_reg;
			port_rd_reg <= (pin_sync_reg & pcfg_reg) | ~pcfg_reg; // RULE7 RULE8
			pos_reg <= pos_sel;
			neg_reg <= use_b ? b_neg_reg : a_neg_reg; // RULE1 RULE3
			sha_reg <= (state_next == ST_SAMPLE); // RULE11
		end
	end

	assign rdata_o = rdata_reg;
	assign port_read_o = port_rd_reg;
	assign mux_ground_o = pcfg_reg; // RULE7
	assign pos_sel_o = pos_reg;
	assign neg_sel_o = neg_reg;
	assign sha_connect_o = sha_reg;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);

	a_conv_length: assert property (start_conv |-> ##13 sar_done) // RULE16
		else $error("conversion did not finish 12 periods after start");
	a_hold_isolated: assert property (sar_busy |-> !sha_connect_o) // RULE11
		else $error("input connected while converting");
	a_result_stored: assert property (sar_done |=> buf_reg[$past(idx_reg)] == $past(sar_result)) // RULE17
		else $error("result not written to buffer slot");
	a_index_steps: assert property (sar_done && idx_reg != seq_last_reg |=> idx_reg == $past(idx_reg) + 4'h1) // RULE22
		else $error("write index did not step");
	a_sequence_restart: assert property (sar_done && idx_reg == seq_last_reg |=> idx_reg == 4'h0) // RULE18
		else $error("sequence did not restart at slot zero");
	a_auto_restart: assert property (sar_done && auto_reg |=> ##1 sha_connect_o) // RULE20
		else $error("auto-start did not resume sampling");
	a_manual_trigger: assert property (state_reg == ST_SAMPLE && trig_reg == TRIG_MANUAL && ctl_wr && !wdata_i[CTL_SAMPLE_BIT] |=> sar_busy) // RULE19
		else $error("clearing sample control did not start conversion");
	a_analog_reads_one: assert property (!pcfg_reg[0] && !$past(pcfg_reg[0]) |=> port_read_o[0]) // RULE8
		else $error("analog pin port read not one");
	a_first_set_pos: assert property (!alt_reg && !scan_en_reg && $stable(a_pos_reg) |=> pos_sel_o == $past(a_pos_reg)) // RULE4
		else $error("first set positive select not routed");
	a_auto_length: assert property (state_reg == ST_SAMPLE && trig_reg == TRIG_AUTO && auto_sample_time_field_reg != 5'h00 && sample_control_bit_cnt_reg == auto_sample_time_field_reg |=> sar_busy) // RULE15
		else $error("auto sample time did not end sampling");

	c_conversion_done: cover property (sar_done);
	c_sequence_wrap: cover property (sar_done && idx_reg == seq_last_reg && seq_last_reg != 4'h0);
	c_alternate_b: cover property (sar_busy && use_b);
	c_scan_step: cover property (sar_done && scan_en_reg && scan_ch_next != scan_ch);
endmodule : ais_ctrl

/* File: ais_analog_model.sv */
// Behavioural analog pins and hold amplifier facing the converter control block
module ais_analog_model import ais_pkg::*; (
	input wire logic clock_i, // Conversion clock
	input wire logic rstn_i, // Async reset, active low
	input wire logic [3:0] pos_sel_i, // Positive mux pin index
	input wire logic neg_sel_i, // Negative mux: 1 pin one, 0 reference
	input wire logic sha_connect_i, // Input connected to hold amplifier
	input wire logic [NUM_PINS-1:0] mux_ground_i, // Mux inputs tied to ground
	input wire logic [RES_BITS-1:0] dac_i, // Trial code
	output logic cmp_o // Held sample at or above trial
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [RES_BITS-1:0] held_reg;
	logic [RES_BITS-1:0] pos_lvl;
	logic [RES_BITS-1:0] neg_lvl;
	logic [RES_BITS-1:0] in_lvl;
	// Fixed ramp of pin levels; a grounded mux input reads zero
	function automatic logic [RES_BITS-1:0] pin_code(input logic [3:0] pin, input logic gnd);
		return gnd ? 10'h000 : 10'h031 + 10'h03b * {6'h00, pin};
	endfunction : pin_code
	// Differential input, clamped at zero like a unipolar converter
	assign pos_lvl = pin_code(pos_sel_i, mux_ground_i[pos_sel_i]);
	assign neg_lvl = neg_sel_i ? pin_code(4'h1, mux_ground_i[1]) : 10'h000;
	assign in_lvl = (pos_lvl > neg_lvl) ? pos_lvl - neg_lvl : 10'h000;
	// Track only while connected, so a late switch of the mux cannot move the held code
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			held_reg <= 10'h000;
		end else if (sha_connect_i) begin
			held_reg <= in_lvl;
		end
	end
	// Ideal comparator, no offset
	assign cmp_o = (held_reg >= dac_i);
endmodule : ais_analog_model

/* File: testbench.sv */
// Self-checking bench for the converter control block with its analog partner
module testbench import ais_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [31:0] sel;
		logic [31:0] ctl;
		logic [3:0] pos;
		logic neg;
		logic [9:0] code;
		logic [3:0] slot;
	} ais_row_s;
	// Select word, control mode, expected mux, expected code and slot
	localparam ais_row_s ROWS [9] = '{
		'{32'h0005_0000, 32'h0000_0000, 4'h5, 1'b0, 10'h158, 4'h0},
		'{32'h0083_0000, 32'h0000_0000, 4'h3, 1'b1, 10'h076, 4'h0},
		'{32'h8f00_0000, 32'h0000_0000, 4'h0, 1'b0, 10'h031, 4'h0},
		'{32'h8c07_0000, 32'h0001_2000, 4'h7, 1'b0, 10'h1ce, 4'h0},
		'{32'h8c07_0000, 32'h0001_2000, 4'hc, 1'b1, 10'h289, 4'h1},
		'{32'h8c09_0000, 32'h0001_2000, 4'h9, 1'b0, 10'h244, 4'h0},
		'{32'h0d09_0000, 32'h0001_2000, 4'hd, 1'b0, 10'h330, 4'h1},
		'{32'h0000_0000, 32'h0001_4000, 4'h4, 1'b0, 10'h11d, 4'h0},
		'{32'h0000_0000, 32'h0001_4000, 4'ha, 1'b0, 10'h27f, 4'h1}
	};
	logic clock_i, rstn_i, wr_i, rd_i, trig_i, cmp_i, neg_sel_o, sha_connect_o;
	logic [7:0] addr_i;
	logic [31:0] wdata_i, rdata_o, rv;
	logic [15:0] pin_level_i, port_read_o, mux_ground_o;
	logic [3:0] pos_sel_o;
	logic [9:0] dac_o;
	logic [9:0] exp_slot [16];
	int fail_count = 0;
	int total_checks = 0;
	int n;
	ais_ctrl u_dut (
		.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trig_i(trig_i), .cmp_i(cmp_i),
		.pin_level_i(pin_level_i), .port_read_o(port_read_o), .mux_ground_o(mux_ground_o),
		.pos_sel_o(pos_sel_o), .neg_sel_o(neg_sel_o), .sha_connect_o(sha_connect_o),
		.dac_o(dac_o)
	);
	ais_analog_model u_analog (
		.clock_i(clock_i), .rstn_i(rstn_i), .pos_sel_i(pos_sel_o), .neg_sel_i(neg_sel_o),
		.sha_connect_i(sha_connect_o), .mux_ground_i(mux_ground_o), .dac_i(dac_o),
		.cmp_o(cmp_i)
	);
	// Verdict in one place, also reached when a wait runs out
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	// Bus master: strobes one cycle, changed just after the rising edge
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		d = rdata_o;
	endtask : bus_rd
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] d;
		bus_rd(a, d);
		chk(d, exp, msg);
	endtask : rd_chk
	// Bounded wait for the hold switch to reach a level, counting cycles
	task automatic wait_sha(input logic lvl, output int c);
		c = 0;
		#1; // Off the edge, so the count does not hinge on update order
		while (sha_connect_o !== lvl && c < 40) begin
			@(posedge clock_i);
			#1;
			c++;
		end
		if (c >= 40) begin
			fail_count++;
			$display("[FAIL] t=%0t hold switch wait ran out", $time);
			final_report();
		end
	endtask : wait_sha
	// One manual sample and convert; the slot must change only late in the window
	task automatic run_row(input ais_row_s r);
		logic [7:0] sa;
		sa = OFF_RESULT_BASE + {2'b00, r.slot, 2'b00};
		bus_wr(OFF_INPUT_SELECT, r.sel);
		bus_wr(OFF_CONTROL, r.ctl | 32'h1);
		repeat (2) @(posedge clock_i);
		#1;
		chk(32'(sha_connect_o), 32'h1, "sampling switch");
		chk(32'(pos_sel_o), 32'(r.pos), "positive mux");
		chk(32'(neg_sel_o), 32'(r.neg), "negative mux");
		chk(32'(dac_o), 32'h0, "idle trial code");
		bus_wr(OFF_CONTROL, r.ctl);
		// Slot is read one cycle before and one cycle after its write
		repeat (10) @(posedge clock_i);
		#1;
		chk(32'(sha_connect_o), 32'h0, "converting switch");
		chk(32'(dac_o == 10'h000), 32'h0, "trial code live");
		rd_chk(sa, 32'(exp_slot[r.slot]), "slot too early");
		rd_chk(sa, 32'(r.code), "result slot");
		bus_rd(OFF_STATUS, rv);
		chk(32'(rv[STA_DONE_BIT]), 32'h1, "done flag");
		exp_slot[r.slot] = r.code;
	endtask : run_row
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	// Main sequence: reset, table of conversions, then the awkward cases
	initial begin
		rstn_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		trig_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 32'h0;
		pin_level_i = 16'h0000;
		foreach (exp_slot[i]) exp_slot[i] = 10'h000;
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		#1;
		chk(32'(port_read_o), 32'h0000_ffff, "analog pins read one");
		chk(32'(mux_ground_o), 32'h0, "no pin grounded");
		rd_chk(OFF_INPUT_SELECT, RESET_WORD, "select reset");
		rd_chk(OFF_PIN_CONFIG, RESET_WORD, "config reset");
		rd_chk(OFF_SCAN_MASK, RESET_WORD, "mask reset");
		$display("test reset done");
		bus_wr(OFF_INPUT_SELECT, 32'hef6f_ffff);
		rd_chk(OFF_INPUT_SELECT, 32'h8f0f_0000, "unimplemented bits");
		rd_chk(8'h20, 32'h0, "unmapped read");
		bus_wr(OFF_SCAN_MASK, 32'h0000_0410);
		rd_chk(OFF_SCAN_MASK, 32'h0000_0410, "mask readback");
		$display("test registers done");
		foreach (ROWS[i]) run_row(ROWS[i]);
		$display("test conversion table done");
		// Digital pins: level passes through, mux input grounded
		bus_wr(OFF_PIN_CONFIG, 32'h0000_a5a5);
		pin_level_i <= 16'h0ff0;
		repeat (5) @(posedge clock_i);
		#1;
		chk(32'(mux_ground_o), 32'h0000_a5a5, "grounded inputs");
		chk(32'(port_read_o), {16'h0000, ~16'ha5a5 | 16'h0ff0}, "port read");
		rd_chk(OFF_PIN_CONFIG, 32'h0000_a5a5, "config readback");
		run_row('{32'h0, 32'h0, 4'h0, 1'b0, 10'h000, 4'h0});
		$display("test pin configuration done");
		// External trigger ends sampling on the next cycle
		bus_wr(OFF_CONTROL, 32'h0000_0003);
		repeat (2) @(posedge clock_i);
		#1;
		chk(32'(sha_connect_o), 32'h1, "trigger mode sampling");
		@(posedge clock_i);
		trig_i <= 1'b1;
		@(posedge clock_i);
		trig_i <= 1'b0;
		@(posedge clock_i);
		#1;
		chk(32'(sha_connect_o), 32'h0, "trigger ends sampling");
		repeat (16) @(posedge clock_i);
		$display("test external trigger done");
		// Counter trigger with auto time 3 and auto-start
		bus_wr(OFF_CONTROL, 32'h0000_031f);
		wait_sha(1'b1, n);
		wait_sha(1'b0, n);
		chk(32'(n), 32'd4, "auto sample length");
		wait_sha(1'b1, n);
		chk(32'(n), 32'd13, "auto restart");
		bus_rd(OFF_CONTROL, rv);
		chk(32'(rv[CTL_SAMPLE_BIT]), 32'h1, "sample bit set by hardware");
		bus_wr(OFF_CONTROL, 32'h0);
		repeat (20) @(posedge clock_i);
		#1;
		chk(32'(sha_connect_o), 32'h0, "stopped");
		$display("test auto sequence done");
		// Reset in mid-conversion brings every output and register back to idle
		bus_wr(OFF_CONTROL, 32'h0000_0001);
		bus_wr(OFF_CONTROL, 32'h0);
		repeat (4) @(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		rstn_i <= 1'b1;
		#1;
		chk(32'(dac_o), 32'h0, "trial code after reset");
		chk(32'(sha_connect_o), 32'h0, "switch after reset");
		chk(32'(port_read_o), 32'h0000_ffff, "port read after reset");
		chk(32'(mux_ground_o), 32'h0, "ground after reset");
		rd_chk(OFF_PIN_CONFIG, RESET_WORD, "config after reset");
		rd_chk(OFF_STATUS, RESET_WORD, "status after reset");
		$display("test reset in conversion done");
		final_report();
	end
endmodule : testbench
